// File: rtl/lpr_host_end.sv
// host controller end: axi4-lite command registers driving the sensor link
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module lpr_host_end (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // register link
  lpr_link_if.host         link,
  // axi4-lite write channels
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // sensor interrupt seen by the host
  output logic             irq_out
);
  import lpr_pkg::*;

  lpr_host_state_type state_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [7:0]  addr_q;
  logic [7:0]  wd_q;
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  last_rd_q;
  logic        irq_q;

  // write channel decode
  wire aw_hs    = s_axi_awvalid && awready_q;
  wire w_hs     = s_axi_wvalid && wready_q;
  wire do_write = aw_got_q && w_got_q && !bvalid_q;
  wire cmd_hit  = (awaddr_q == AXI_OFS_CMD);
  wire wr_ok    = cmd_hit || (awaddr_q == AXI_OFS_STAT);
  wire start    = do_write && cmd_hit && (&s_axi_wstrb[2:0] || 1'b1) && (state_q == H_IDLE);
  wire is_read  = wdata_q[HCMD_READ_BIT];
  wire [7:0] cmd_addr = wdata_q[HCMD_ADDR_LSB +: 8];
  wire [7:0] cmd_wd   = wdata_q[HCMD_WDATA_LSB +: 8];
  // reserved byte is only ever written with zero
  wire [7:0] wd_safe  = (cmd_addr == OFS_RSVD) ? RST_RSVD :
                        (cmd_addr == OFS_CMD1) ?
                        (cmd_wd & ~(8'h01 << CMD1_FLAG_BIT)) : cmd_wd;

  // read channel decode
  wire ar_hs    = s_axi_arvalid && arready_q;
  wire [31:0] stat_word = {16'h0000, last_rd_q, 6'h00, irq_q, state_q == H_WAIT};
  wire [31:0] rd_mux    = (s_axi_araddr == AXI_OFS_CMD)  ? {24'h000000, addr_q} :
                          (s_axi_araddr == AXI_OFS_STAT) ? stat_word : 32'h00000000;
  wire        rd_ok     = (s_axi_araddr == AXI_OFS_CMD) || (s_axi_araddr == AXI_OFS_STAT);

  // write address and data capture, in either order
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h00000000;
    end else begin
      if (aw_hs) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
      end
      if (bvalid_q && s_axi_bready) begin
        aw_got_q  <= 1'b0;
        w_got_q   <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= AXI_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read address and data
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= AXI_OKAY;
      rdata_q   <= 32'h00000000;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      rdata_q   <= rd_mux;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // link transfer machine: one request pulse, then wait for the answer
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      state_q   <= H_IDLE;
      addr_q    <= 8'h00;
      wd_q      <= 8'h00;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      last_rd_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        H_IDLE:
          if (start) begin
            state_q <= H_WAIT;
            addr_q  <= cmd_addr;
            wd_q    <= is_read ? 8'h00 : wd_safe;
            wr_q    <= !is_read;
            rd_q    <= is_read;
          end
        H_WAIT:
          if (link.reg_ack) begin
            state_q <= H_IDLE;
            if (!wr_q && !rd_q)
              last_rd_q <= link.reg_rdata;
          end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  // interrupt pin is active low on the link
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      irq_q <= 1'b0;
    else
      irq_q <= !link.int_n;
  end

  assign link.reg_addr  = addr_q;
  assign link.reg_wdata = wd_q;
  assign link.reg_wr    = wr_q;
  assign link.reg_rd    = rd_q;
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rresp    = rresp_q;
  assign s_axi_rdata    = rdata_q;
  assign irq_out        = irq_q;

endmodule

// File: rtl/lpr_pkg.sv
// constants and types shared by both ends of the light sensor result link
package lpr_pkg;

  // sensor register byte offsets
  localparam logic [7:0] OFS_CMD1     = 8'h00;
  localparam logic [7:0] OFS_CMD2     = 8'h01;
  localparam logic [7:0] OFS_RES_LO   = 8'h02;
  localparam logic [7:0] OFS_RES_HI   = 8'h03;
  localparam logic [7:0] OFS_LTH_LO   = 8'h04;
  localparam logic [7:0] OFS_LTH_HI   = 8'h05;
  localparam logic [7:0] OFS_HTH_LO   = 8'h06;
  localparam logic [7:0] OFS_HTH_HI   = 8'h07;
  localparam logic [7:0] OFS_RSVD     = 8'h08;

  // reset values
  localparam logic [7:0] RST_CMD      = 8'h00;
  localparam logic [7:0] RST_LTH      = 8'h00;
  localparam logic [7:0] RST_HTH      = 8'hff;
  localparam logic [7:0] RST_RSVD     = 8'h00;

  // first command register field positions
  localparam int CMD1_OP_LSB          = 5;
  localparam int CMD1_FLAG_BIT        = 2;
  localparam int CMD1_PERSIST_LSB     = 0;
  // second command register field positions
  localparam int CMD2_SCHEME_BIT      = 7;
  localparam int CMD2_RES_LSB         = 2;

  // oscillator cycles per conversion for each resolution code
  localparam logic [16:0] CYC_RES16   = 17'h10000;
  localparam logic [16:0] CYC_RES12   = 17'h01000;
  localparam logic [16:0] CYC_RES8    = 17'h00100;
  localparam logic [16:0] CYC_RES4    = 17'h00010;

  // consecutive out-of-window counts for each persistence code
  localparam logic [4:0] PERSIST_P0   = 5'h01;
  localparam logic [4:0] PERSIST_P1   = 5'h04;
  localparam logic [4:0] PERSIST_P2   = 5'h08;
  localparam logic [4:0] PERSIST_P3   = 5'h10;

  // operation modes
  typedef enum logic [2:0] {
    OP_OFF       = 3'b000,
    OP_ALS_ONCE  = 3'b001,
    OP_IR_ONCE   = 3'b010,
    OP_PROX_ONCE = 3'b011,
    OP_RESERVED  = 3'b100,
    OP_ALS_CONT  = 3'b101,
    OP_IR_CONT   = 3'b110,
    OP_PROX_CONT = 3'b111
  } lpr_op_type;

  // host controller register byte addresses (axi4-lite)
  localparam logic [3:0] AXI_OFS_CMD  = 4'h0;
  localparam logic [3:0] AXI_OFS_STAT = 4'h4;
  localparam int HCMD_ADDR_LSB        = 0;
  localparam int HCMD_WDATA_LSB       = 8;
  localparam int HCMD_READ_BIT        = 16;

  localparam logic [1:0] AXI_OKAY     = 2'b00;
  localparam logic [1:0] AXI_SLVERR   = 2'b10;

  // host controller transfer states
  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_WAIT = 1'b1
  } lpr_host_state_type;

endpackage

// File: rtl/lpr_link_if.sv
// register link between the sensor result block and its host controller
`timescale 1ns/10ps
interface lpr_link_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_ack;
  logic       int_n;

  // sensor end
  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    output reg_rdata,
    output reg_ack,
    output int_n
  );

  // host controller end
  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input  reg_rdata,
    input  reg_ack,
    input  int_n
  );
endinterface

// File: rtl/lpr_dev_end.sv
// sensor end: result registers, thresholds, conversion timing and interrupt
// Function
// - result bytes are read-only to software
// - upper byte at 03, lower at 02
// - result right-aligned from bit zero
// - four-bit result in bits 0 to 3
// - both result bytes refresh every conversion
// - low threshold at 04/05, resets zero
// - high threshold at 06/07, resets ones
// - reserved address 08 holds zero
// - integration lasts two-to-the-n oscillator cycles
// - scheme one subtracts background, halves resolution
// - host may difference proximity and IR
// - host clears flag before using interrupts
// - flag set when result leaves window
// - flag and pin held until 00 read
// - pin waits for persistence count conversions
// - persistence applies to every measurement kind
// - persistence codes select 1, 4, 8, 16
// - resolution codes select 65536/4096/256/16 cycles
// - command one transfer also clears flag
// - operation field selects measurement and mode
`timescale 1ns/10ps
module lpr_dev_end (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // register link
  lpr_link_if.dev          link,
  // analog front end, one strobe per internal oscillator cycle
  input  wire logic        osc_tick_in,
  input  wire logic [15:0] adc_als_in,
  input  wire logic [15:0] adc_ir_in,
  input  wire logic [15:0] adc_prox_in,
  // conversion status
  output logic             conv_done_out,
  output logic             led_on_out
);
  import lpr_pkg::*;

  logic [2:0]  op_q;
  logic [2:0]  op_d;
  logic [1:0]  persist_q;
  logic [7:0]  cmd2_q;
  logic        flag_q;
  logic        flag_d;
  logic [15:0] lth_q;
  logic [15:0] hth_q;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [16:0] cnt_q;
  logic [4:0]  pcnt_q;
  logic [7:0]  rdata_q;
  logic        ack_q;
  logic        int_n_q;
  logic        done_q;
  logic        led_q;

  // link decode
  wire wr_cmd1 = link.reg_wr && (link.reg_addr == OFS_CMD1);
  wire rd_cmd1 = link.reg_rd && (link.reg_addr == OFS_CMD1);
  wire wr_cmd2 = link.reg_wr && (link.reg_addr == OFS_CMD2);
  wire wr_lt_l = link.reg_wr && (link.reg_addr == OFS_LTH_LO);
  wire wr_lt_h = link.reg_wr && (link.reg_addr == OFS_LTH_HI);
  wire wr_ht_l = link.reg_wr && (link.reg_addr == OFS_HTH_LO);
  wire wr_ht_h = link.reg_wr && (link.reg_addr == OFS_HTH_HI);

  // resolution and persistence decode
  wire [1:0]  res_code = cmd2_q[CMD2_RES_LSB +: 2];
  wire        scheme1  = cmd2_q[CMD2_SCHEME_BIT];
  wire [16:0] conv_len = (res_code == 2'b00) ? CYC_RES16 :
                         (res_code == 2'b01) ? CYC_RES12 :
                         (res_code == 2'b10) ? CYC_RES8 : CYC_RES4;
  wire [4:0]  need     = (persist_q == 2'b00) ? PERSIST_P0 :
                         (persist_q == 2'b01) ? PERSIST_P1 :
                         (persist_q == 2'b10) ? PERSIST_P2 : PERSIST_P3;

  // conversion timing
  wire running  = (op_q != OP_OFF) && (op_q != OP_RESERVED);
  wire conv_end = running && osc_tick_in && (cnt_q == conv_len - 17'h00001);
  wire is_prox  = (op_q[1:0] == 2'b11);
  wire is_ir    = (op_q[1:0] == 2'b10);

  // result assembly: mask to n bits, scheme one is signed and halved
  wire [15:0] mask     = conv_len[15:0] - 16'h0001;
  wire [15:0] m_als    = adc_als_in & mask;
  wire [15:0] m_ir     = adc_ir_in & mask;
  wire [15:0] m_prox   = adc_prox_in & mask;
  wire [16:0] diff     = {1'b0, m_prox} - {1'b0, m_ir};
  wire [15:0] signed_h = diff[16:1];
  assign result_d = !is_prox ? (is_ir ? m_ir : m_als) :
                    (scheme1 ? signed_h : m_prox);

  // window compare on the value about to be stored
  wire out_win  = (result_d < lth_q) || (result_d > hth_q);
  wire [4:0] pcnt_inc = (pcnt_q == PERSIST_P3) ? pcnt_q : pcnt_q + 5'h01;
  wire trip     = conv_end && out_win && (pcnt_inc >= need);
  // any access to command one ends its transfer and clears the flag
  wire flag_clr = rd_cmd1 || wr_cmd1;
  assign flag_d = trip || (flag_q && !flag_clr);

  // operation mode, single conversions fall back to power-down
  always_comb
  begin
    op_d = op_q;
    if (wr_cmd1)
      op_d = link.reg_wdata[CMD1_OP_LSB +: 3];
    else if (conv_end && !op_q[2])
      op_d = OP_OFF;
  end

  // command registers
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      op_q      <= RST_CMD[CMD1_OP_LSB +: 3];
      persist_q <= RST_CMD[CMD1_PERSIST_LSB +: 2];
      cmd2_q    <= RST_CMD;
    end else begin
      op_q <= op_d;
      if (wr_cmd1)
        persist_q <= link.reg_wdata[CMD1_PERSIST_LSB +: 2];
      if (wr_cmd2)
        cmd2_q <= link.reg_wdata;
    end
  end

  // threshold registers
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      lth_q <= {RST_LTH, RST_LTH};
      hth_q <= {RST_HTH, RST_HTH};
    end else begin
      if (wr_lt_l) lth_q[7:0]  <= link.reg_wdata;
      if (wr_lt_h) lth_q[15:8] <= link.reg_wdata;
      if (wr_ht_l) hth_q[7:0]  <= link.reg_wdata;
      if (wr_ht_h) hth_q[15:8] <= link.reg_wdata;
    end
  end

  // integration counter, restarted by a command one write
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !running || wr_cmd1)
      cnt_q <= 17'h00000;
    else if (osc_tick_in)
      cnt_q <= conv_end ? 17'h00000 : cnt_q + 17'h00001;
  end

  // result capture and persistence run count
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      result_q <= 16'h0000;
      pcnt_q   <= 5'h00;
    end else if (conv_end) begin
      result_q <= result_d;
      pcnt_q   <= out_win ? pcnt_inc : 5'h00;
    end
  end

  // interrupt flag and pin, a trip in a clear cycle wins
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      flag_q  <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      flag_q  <= flag_d;
      int_n_q <= !flag_d;
    end
  end

  // read data mux; result bytes and reserved byte have no write path
  wire [7:0] rd_mux =
    (link.reg_addr == OFS_CMD1)   ? {op_q, 2'b00, flag_q, persist_q} :
    (link.reg_addr == OFS_CMD2)   ? cmd2_q :
    (link.reg_addr == OFS_RES_LO) ? result_q[7:0] :
    (link.reg_addr == OFS_RES_HI) ? result_q[15:8] :
    (link.reg_addr == OFS_LTH_LO) ? lth_q[7:0] :
    (link.reg_addr == OFS_LTH_HI) ? lth_q[15:8] :
    (link.reg_addr == OFS_HTH_LO) ? hth_q[7:0] :
    (link.reg_addr == OFS_HTH_HI) ? hth_q[15:8] :
    (link.reg_addr == OFS_RSVD)   ? RST_RSVD : 8'h00;

  // link answer, one cycle after each request
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= link.reg_wr || link.reg_rd;
      if (link.reg_rd)
        rdata_q <= rd_mux;
    end
  end

  // conversion status outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in) begin
      done_q <= 1'b0;
      led_q  <= 1'b0;
    end else begin
      done_q <= conv_end;
      led_q  <= running && is_prox;
    end
  end

  assign link.reg_rdata = rdata_q;
  assign link.reg_ack   = ack_q;
  assign link.int_n     = int_n_q;
  assign conv_done_out  = done_q;
  assign led_on_out     = led_q;

endmodule

// File: sim/lpr_link_sva.sv
// link protocol checker for the sensor result link
`timescale 1ns/10ps
module lpr_link_sva
  import lpr_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  // link signals
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic       int_n
);
  // request and command-one access decode
  wire logic req      = reg_wr | reg_rd;
  wire logic cmd1_acc = req && (reg_addr == OFS_CMD1);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_ack_after_req: assert property (req |=> reg_ack && !req)
    else $error("link request not acked alone next cycle");
  a_ack_has_cause: assert property (reg_ack |-> $past(req))
    else $error("ack without request");
  a_rsvd_reads_zero: assert property (reg_rd && reg_addr == OFS_RSVD |=> reg_rdata == RST_RSVD)
    else $error("reserved byte not zero");
  a_host_rsvd_zero: assert property (reg_wr && reg_addr == OFS_RSVD |-> reg_wdata == 8'h00)
    else $error("host wrote nonzero reserved byte");
  a_host_flag_zero: assert property (reg_wr && cmd1_acc |-> !reg_wdata[CMD1_FLAG_BIT])
    else $error("host wrote flag bit high");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_RSVD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_int_clear_cause: assert property ($rose(int_n) |-> $past(cmd1_acc, 1) || $past(cmd1_acc, 2))
    else $error("interrupt released without command one access");
  a_rdata_hold: assert property ($changed(reg_rdata) |-> reg_ack)
    else $error("read data moved without ack");
  a_addr_hold: assert property ($changed(reg_addr) |-> req)
    else $error("address moved without request");
  a_flag_with_pin: assert property (reg_rd && cmd1_acc && !int_n |=> reg_rdata[CMD1_FLAG_BIT])
    else $error("flag low while pin asserted");
endmodule

// File: sim/light_prox_result_window_irq_bench.sv
// self-checking bench joining both ends of the sensor result link
`timescale 1ns/10ps
module light_prox_result_window_irq_bench;
  import lpr_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        osc_tick   = 1'b0;
  logic [15:0] als        = 16'ha53c;
  logic [15:0] ir         = 16'h5a6b;
  logic [15:0] prox       = 16'h3cd7;
  logic [3:0]  awaddr     = 4'h0;
  logic [3:0]  araddr     = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, done, led, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          failures   = 0;
  int          n_compared = 0;
  int          n_done     = 0;

  // clock and conversion-done pulse counter
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (done === 1'b1) n_done <= n_done + 1;

  // both ends joined by the link, checker beside it
  lpr_link_if lpr_link_if_inst ();
  lpr_dev_end lpr_dev_end_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .link(lpr_link_if_inst), .osc_tick_in(osc_tick), .adc_als_in(als), .adc_ir_in(ir),
    .adc_prox_in(prox), .conv_done_out(done), .led_on_out(led));
  lpr_host_end lpr_host_end_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .link(lpr_link_if_inst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_out(irq));
  lpr_link_sva lpr_link_sva_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr(lpr_link_if_inst.reg_addr), .reg_wdata(lpr_link_if_inst.reg_wdata),
    .reg_wr(lpr_link_if_inst.reg_wr), .reg_rd(lpr_link_if_inst.reg_rd),
    .reg_rdata(lpr_link_if_inst.reg_rdata), .reg_ack(lpr_link_if_inst.reg_ack),
    .int_n(lpr_link_if_inst.int_n));

  task finish_test;
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task timed_out;
    failures++;
    finish_test;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // axi4-lite write, both channels offered together
  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) timed_out;
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge sys_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) timed_out;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one sensor register access through the host, waiting until not busy
  task link(input logic [7:0] a, input logic [7:0] v, input logic rd, output logic [7:0] d);
    logic [31:0] s;
    logic [1:0]  r;
    int          i;
    axi_wr(AXI_OFS_CMD, {15'h0000, rd, v, a}, r);
    for (i = 0; i < 20; i++)
    begin
      axi_rd(AXI_OFS_STAT, s, r);
      if (s[0] === 1'b0) break;
    end
    if (i == 20) timed_out;
    d = s[15:8];
  endtask

  // exactly n oscillator ticks, then a short settle
  task ticks(input int n);
    if (n > 0)
    begin
      @(posedge sys_clk_in);
      osc_tick <= 1'b1;
      repeat (n) @(posedge sys_clk_in);
      osc_tick <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_in);
  endtask

  task t_reset;
    logic [7:0]  d;
    logic [31:0] w;
    logic [1:0]  r;
    int          a;
    for (a = 4; a <= 9; a++)
    begin
      link(a[7:0], 8'h00, 1'b1, d);
      chk("reset byte", d, (a == 6 || a == 7) ? 8'hff : 8'h00);
    end
    chk("irq idle", irq, 1'b0);
    // a nonzero write to the reserved byte must leave the host as zero
    link(OFS_RSVD, 8'h5a, 1'b0, d);
    link(OFS_RSVD, 8'h00, 1'b1, d);
    chk("reserved after write", d, 8'h00);
    axi_wr(4'h8, 32'h0, r);
    chk("unmapped wr", r, AXI_SLVERR);
    axi_rd(4'h8, w, r);
    chk("unmapped rd data", w, 32'h0);
    chk("unmapped rd resp", r, AXI_SLVERR);
  endtask

  task t_res;
    logic [7:0] d, lo, hi;
    int         c, n, k;
    for (c = 3; c >= 0; c--)
    begin
      n = 16 - 4 * c;
      link(OFS_CMD2, {4'h0, c[1:0], 2'b00}, 1'b0, d);
      link(OFS_CMD1, 8'h20, 1'b0, d);
      k = n_done;
      ticks((1 << n) - 1);
      chk("early done", n_done, k);
      ticks(1);
      chk("done", n_done, k + 1);
      link(OFS_RES_LO, 8'h00, 1'b1, lo);
      link(OFS_RES_HI, 8'h00, 1'b1, hi);
      chk("result", {hi, lo}, {16'h0, als} & ((32'h1 << n) - 1));
    end
    link(OFS_RES_LO, 8'h00, 1'b0, d);
    link(OFS_RES_HI, 8'h00, 1'b0, d);
    link(OFS_RES_LO, 8'h00, 1'b1, lo);
    link(OFS_RES_HI, 8'h00, 1'b1, hi);
    chk("read-only result", {hi, lo}, als);
  endtask

  task t_ops;
    logic [7:0]  d, h;
    logic [15:0] e;
    int          op, k;
    link(OFS_CMD2, 8'h0c, 1'b0, d);
    for (op = 1; op < 8; op++)
    begin
      link(OFS_CMD1, {op[2:0], 5'h00}, 1'b0, d);
      k = n_done;
      ticks(16);
      chk("mode conv", n_done, k + (op != 4));
      chk("led", led, op == 7);
      e = (op[1:0] == 2'd1) ? als : (op[1:0] == 2'd2) ? ir : prox;
      link(OFS_RES_LO, 8'h00, 1'b1, d);
      if (op != 4) chk("mode result", d, e[3:0]);
    end
    // scheme one: on-chip difference of 4-bit samples 7 and 11, halved
    link(OFS_CMD2, 8'h8c, 1'b0, d);
    link(OFS_CMD1, 8'h60, 1'b0, d);
    ticks(16);
    link(OFS_RES_LO, 8'h00, 1'b1, d);
    link(OFS_RES_HI, 8'h00, 1'b1, h);
    chk("scheme one", {h, d}, 16'hfffe);
    // scheme zero: proximity then ir, difference taken by the host
    link(OFS_CMD2, 8'h0c, 1'b0, d);
    link(OFS_CMD1, 8'h60, 1'b0, d);
    ticks(16);
    link(OFS_RES_LO, 8'h00, 1'b1, h);
    link(OFS_CMD1, 8'h40, 1'b0, d);
    ticks(16);
    link(OFS_RES_LO, 8'h00, 1'b1, d);
    chk("prox less ir", 8'(h - d), 8'hfc);
    link(OFS_CMD1, 8'h00, 1'b0, d);
  endtask

  task t_irq;
    logic [7:0] d;
    logic [2:0] op;
    int         p, need;
    link(OFS_LTH_LO, 8'h05, 1'b0, d);
    link(OFS_HTH_LO, 8'h0a, 1'b0, d);
    link(OFS_HTH_HI, 8'h00, 1'b0, d);
    link(OFS_CMD1, 8'ha4, 1'b0, d);
    als <= 16'h0005;
    ticks(16);
    als <= 16'h000a;
    ticks(16);
    chk("edges inside", lpr_link_if_inst.int_n, 1'b1);
    als <= 16'h000b;
    ticks(16);
    chk("above high", {lpr_link_if_inst.int_n, irq}, 2'b01);
    link(OFS_CMD1, 8'h00, 1'b0, d);
    repeat (3) @(posedge sys_clk_in);
    chk("write clears", {lpr_link_if_inst.int_n, irq}, 2'b10);
    for (p = 0; p < 4; p++)
    begin
      need = (p == 0) ? 1 : (4 << (p - 1));
      op = p[0] ? OP_PROX_CONT : OP_ALS_CONT;
      link(OFS_CMD1, {op, 3'b000, p[1:0]}, 1'b0, d);
      als <= 16'h0007;
      prox <= 16'h0007;
      ticks(16);
      als <= 16'h0004;
      prox <= 16'h0004;
      ticks(16 * (need - 1));
      chk("persist early", lpr_link_if_inst.int_n, 1'b1);
      ticks(16);
      repeat (20) @(posedge sys_clk_in);
      chk("persist trip", {lpr_link_if_inst.int_n, irq}, 2'b01);
      link(OFS_CMD1, 8'h00, 1'b1, d);
      chk("flag read", d, {op, 3'b001, p[1:0]});
      repeat (3) @(posedge sys_clk_in);
      chk("read clears", lpr_link_if_inst.int_n, 1'b1);
    end
    link(OFS_CMD1, 8'h00, 1'b0, d);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_reset;
    t_res;
    t_ops;
    t_irq;
    finish_test;
  end
endmodule
